/* File: hw/fast_step_sequencer.sv */
/*
  Fast step sequencer: step table, loop control, fill helper, AHB-Lite registers.
  Assumes a single AHB-Lite master, word transfers only, and a load stage
  that takes setpoint, load_on and mode_cr from load_out every cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module fast_step_sequencer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output fseq_pkg::load_drive_t load_out,
  output logic step_pulse_output
);
  import fseq_pkg::*;

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic in_range(input logic [IDX_W-1:0] i, input logic [IDX_W-1:0] lo,
                                    input logic [IDX_W-1:0] hi);
    in_range = (lo != '0) && (i >= lo) && (i <= hi);
  endfunction

  bus_req_t req;
  logic constant_resistance_mode;
  logic end_hold_en;
  logic loop_infinite;
  logic prefill;
  logic [LOOP_W-1:0] loop_count;
  logic [IDX_W-1:0] loop_final_index;
  logic [TB_W-1:0] time_base;
  logic [VAL_W-1:0] end_hold_value;
  logic [VAL_W-1:0] fill_start_value;
  logic [VAL_W-1:0] fill_end_value;
  logic [IDX_W-1:0] fill_first;
  logic [IDX_W-1:0] fill_last;
  logic [IDX_W-1:0] step_sel;
  logic [IDX_W-1:0] step_count;
  logic [IDX_W-1:0] active_step;
  logic [LOOP_W-1:0] loop_num;
  logic short_err;
  logic [3:0] pulse_cnt;
  logic [IDX_W-1:0] f_cur;
  logic [IDX_W-1:0] f_stop;
  seq_state_t state;
  fill_state_t fstate;
  step_entry_t table_mem [0:STEPS_MAX-1];

  // Bus decode
  wire addr_phase = hsel && hready && htrans[1];
  wire [7:0] raddr = (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
  wire wr_en = req.valid && req.write;
  wire wr_ctrl = wr_en && req.addr == OFS_CTRL;
  wire wr_cmd = wr_en && req.addr == OFS_CMD;
  wire wr_step_data = wr_en && req.addr == OFS_STEP_DATA;
  wire fill_busy = fstate != fl_idle;
  wire cmd_start = wr_cmd && hwdata[CMD_START];
  wire cmd_stop = wr_cmd && hwdata[CMD_STOP];
  wire cmd_insert = wr_cmd && hwdata[CMD_INSERT] && !fill_busy;
  wire cmd_delete = wr_cmd && hwdata[CMD_DELETE] && !fill_busy;
  wire cmd_fill = wr_cmd && hwdata[CMD_FILL] && !fill_busy;

  // Table edits
  wire [IDX_W-1:0] new_idx = step_count + 10'h001;
  wire ins_ok = cmd_insert && step_count < IDX_W'(STEPS_MAX);
  wire del_ok = cmd_delete && step_count > STEPS_MIN;
  wire ins_fill = ins_ok && prefill && in_range(new_idx, fill_first, fill_last);
  wire [IDX_W-1:0] post_stop = (fill_last < step_count) ? fill_last : step_count;
  wire post_fill = cmd_fill && in_range(fill_first, fill_first, post_stop);
  wire bus_tab_wr = wr_step_data && !fill_busy && step_sel != '0;
  wire div_done;
  wire [VAL_W-1:0] div_result;
  wire fill_wr = fstate == fl_wait && div_done;

  // Sequencing
  wire step_end;
  wire [IDX_W-1:0] last_step = (loop_final_index < step_count) ? loop_final_index : step_count;
  wire start_ok = cmd_start && step_count >= STEPS_MIN;
  wire at_last = active_step >= last_step;
  wire more_loops = loop_infinite || loop_num < loop_count;
  wire advance = state == st_run && step_end;
  wire finish = advance && at_last && !more_loops;
  wire new_step = start_ok || (advance && !finish);
  wire [IDX_W-1:0] next_step = (start_ok || at_last) ? 10'h001 : active_step + 10'h001;
  step_entry_t cur_entry;
  step_entry_t sel_entry;
  assign cur_entry = table_mem[next_step - 10'h001];
  assign sel_entry = table_mem[step_sel - 10'h001];

  // Read data
  wire [31:0] status_word = {6'h00, step_count, 12'h000, short_err, fill_busy,
                             state == st_done, state == st_run};
  wire [31:0] read_value =
    (raddr == OFS_CTRL) ? {28'h0, prefill, loop_infinite, end_hold_en,
                           constant_resistance_mode} :
    (raddr == OFS_LOOPS) ? 32'(loop_count) :
    (raddr == OFS_FINAL) ? 32'(loop_final_index) :
    (raddr == OFS_TIME_BASE) ? 32'(time_base) :
    (raddr == OFS_HOLD_VALUE) ? 32'(end_hold_value) :
    (raddr == OFS_STEP_SEL) ? 32'(step_sel) :
    (raddr == OFS_STEP_DATA && step_sel != '0) ? 32'(sel_entry) :
    (raddr == OFS_FILL_START) ? 32'(fill_start_value) :
    (raddr == OFS_FILL_END) ? 32'(fill_end_value) :
    (raddr == OFS_FILL_RANGE) ? {6'h00, fill_last, 6'h00, fill_first} :
    (raddr == OFS_STATUS) ? status_word :
    (raddr == OFS_POSITION) ? {2'h0, loop_num, 6'h00, active_step} : 32'h00000000;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req <= '0;
      hrdata <= 32'h00000000;
    end else begin
      req <= {addr_phase, hwrite, raddr};
      if (addr_phase && !hwrite) begin
        hrdata <= read_value;
      end
    end
  end

  // Settings registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {prefill, loop_infinite, end_hold_en, constant_resistance_mode} <= 4'h0;
      loop_count <= RST_LOOPS;
      loop_final_index <= RST_FINAL;
      time_base <= RST_TIME_BASE;
      end_hold_value <= '0;
      fill_start_value <= '0;
      fill_end_value <= '0;
      fill_first <= '0;
      fill_last <= '0;
    end else if (wr_en) begin
      // One mode bit picks current or resistance, no ramp setting exists
      if (wr_ctrl) begin
        {prefill, loop_infinite, end_hold_en, constant_resistance_mode} <= hwdata[3:0];
      end
      if (req.addr == OFS_LOOPS) begin
        loop_count <= LOOP_W'(clamp(hwdata, 32'h1, 32'(LOOP_MAX)));
      end
      if (req.addr == OFS_FINAL) begin
        loop_final_index <= IDX_W'(clamp(hwdata, 32'h1, 32'(STEPS_MAX)));
      end
      if (req.addr == OFS_TIME_BASE) begin
        time_base <= TB_W'(clamp(hwdata, 32'h1, 32'(TIME_BASE_MAX)));
      end
      if (req.addr == OFS_HOLD_VALUE) begin
        end_hold_value <= hwdata[VAL_W-1:0];
      end
      if (req.addr == OFS_FILL_START) begin
        fill_start_value <= hwdata[VAL_W-1:0];
      end
      if (req.addr == OFS_FILL_END) begin
        fill_end_value <= hwdata[VAL_W-1:0];
      end
      if (req.addr == OFS_FILL_RANGE && !fill_busy) begin
        fill_first <= IDX_W'(clamp(32'(hwdata[IDX_W-1:0]), 32'h1, 32'(STEPS_MAX)));
        fill_last <= IDX_W'(clamp(32'(hwdata[HI_FIELD+IDX_W-1:HI_FIELD]), 32'h1,
                                  32'(STEPS_MAX)));
      end
    end
  end

  // Step count and selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      step_count <= '0;
      step_sel <= '0;
    end else if (ins_ok) begin
      step_count <= new_idx;
      step_sel <= new_idx;
    end else if (del_ok) begin
      step_count <= step_count - 10'h001;
      step_sel <= step_count - 10'h001;
    end else if (wr_en && req.addr == OFS_STEP_SEL) begin
      step_sel <= IDX_W'(clamp(32'(hwdata[IDX_W-1:0]), 32'h1, 32'(step_count)));
    end
  end

  // Table write port
  always_ff @(posedge hclk) begin
    if (fill_wr) begin
      table_mem[f_cur - 10'h001].value <= div_result;
    end else if (ins_ok) begin
      table_mem[step_count] <= '0;
    end else if (bus_tab_wr) begin
      table_mem[step_sel - 10'h001] <= {hwdata[TRIG_BIT], hwdata[VAL_W-1:0]};
    end
  end

  // Fill engine walks the range one step at a time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fstate <= fl_idle;
      f_cur <= '0;
      f_stop <= '0;
    end else begin
      case (fstate)
        fl_idle: begin
          if (ins_fill) begin
            f_cur <= new_idx;
            f_stop <= new_idx;
            fstate <= fl_launch;
          end else if (post_fill) begin
            f_cur <= fill_first;
            f_stop <= post_stop;
            fstate <= fl_launch;
          end
        end
        fl_launch: begin
          fstate <= fl_wait;
        end
        fl_wait: begin
          if (div_done) begin
            f_cur <= f_cur + 10'h001;
            fstate <= (f_cur >= f_stop) ? fl_idle : fl_launch;
          end
        end
        default: begin
          fstate <= fl_idle;
        end
      endcase
    end
  end

  fill_interp u_interp (
    .hclk(hclk),
    .hresetn(hresetn),
    .go(fstate == fl_launch),
    .start_value(fill_start_value),
    .end_value(fill_end_value),
    .first_idx(fill_first),
    .last_idx(fill_last),
    .idx(f_cur),
    .busy(),
    .done(div_done),
    .result(div_result)
  );

  step_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .reload(start_ok),
    .period_ticks(time_base),
    .step_end(step_end)
  );

  // Sequence state, loops and load drive
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= st_idle;
      active_step <= '0;
      loop_num <= '0;
      short_err <= 1'b0;
      load_out <= '0;
    end else begin
      if (cmd_start) begin
        short_err <= !start_ok;
      end
      if (cmd_stop && !cmd_start) begin
        state <= st_idle;
        load_out.load_on <= 1'b0;
        load_out.setpoint <= '0;
      end else if (new_step) begin
        state <= st_run;
        active_step <= next_step;
        loop_num <= start_ok ? 14'h0001 : (at_last ? loop_num + 14'h0001 : loop_num);
        load_out.setpoint <= cur_entry.value;
        load_out.load_on <= 1'b1;
        if (start_ok) begin
          load_out.mode_cr <= constant_resistance_mode;
        end
      end else if (finish) begin
        state <= st_done;
        load_out.load_on <= end_hold_en;
        load_out.setpoint <= end_hold_en ? end_hold_value : '0;
      end
    end
  end

  // Trigger pulse starts with the step setpoint
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pulse_cnt <= 4'h0;
      step_pulse_output <= 1'b0;
    end else if (new_step && cur_entry.trig && !(cmd_stop && !cmd_start)) begin
      pulse_cnt <= 4'(PULSE_CYCLES - 1);
      step_pulse_output <= 1'b1;
    end else if (pulse_cnt != 4'h0) begin
      pulse_cnt <= pulse_cnt - 4'h1;
    end else begin
      step_pulse_output <= 1'b0;
    end
  end

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_finish_hold;
    finish && end_hold_en && !cmd_stop && !cmd_start;
  endsequence
  sequence s_trig_step;
    new_step && cur_entry.trig && !cmd_stop;
  endsequence

  a_loop_bound: assert property (state == st_run
    |-> loop_infinite || loop_num <= loop_count)
    else $error("loop number passed the loop count");
  a_hold_level: assert property (s_finish_hold |=> load_out.load_on &&
    load_out.setpoint == $past(end_hold_value) && state == st_done)
    else $error("end-hold level not applied");
  a_release_load: assert property (finish && !end_hold_en && !cmd_stop && !cmd_start
    |=> !load_out.load_on)
    else $error("load left on without end-hold");
  a_loop_wrap: assert property (advance && at_last && more_loops && !cmd_start && !cmd_stop
    |=> active_step == 10'h001 && loop_num == $past(loop_num) + 14'h0001)
    else $error("loop did not wrap to the first step");
  a_short_refused: assert property (cmd_start && step_count < STEPS_MIN
    |=> short_err && state != $past(state) == 1'b0)
    else $error("short sequence was started");
  a_step_value: assert property (new_step && !cmd_stop
    |=> load_out.setpoint == $past(cur_entry.value) && load_out.load_on)
    else $error("step setpoint not driven");
  a_step_index: assert property (state == st_run |-> active_step >= 10'h001 &&
    active_step <= step_count)
    else $error("current step outside the table");
  a_trig_pulse: assert property (s_trig_step |=> step_pulse_output [*8])
    else $error("trigger pulse too short");
  a_no_trig: assert property (new_step && !cur_entry.trig && !step_pulse_output
    |=> !step_pulse_output)
    else $error("trigger pulse on a step without trigger flag");
endmodule
`default_nettype wire

/* File: hw/fill_interp.sv */
/*
  Linear interpolation of one fill setpoint by a serial divider.
  Assumes first_idx <= idx <= last_idx while go is pulsed.
*/
`timescale 1ns/1ps
`default_nettype none
module fill_interp (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [fseq_pkg::VAL_W-1:0] start_value,
  input wire logic [fseq_pkg::VAL_W-1:0] end_value,
  input wire logic [fseq_pkg::IDX_W-1:0] first_idx,
  input wire logic [fseq_pkg::IDX_W-1:0] last_idx,
  input wire logic [fseq_pkg::IDX_W-1:0] idx,
  output logic busy,
  output logic done,
  output logic [fseq_pkg::VAL_W-1:0] result
);
  import fseq_pkg::*;
  localparam int NUM_W = VAL_W + IDX_W;

  logic [NUM_W-1:0] quo;
  logic [IDX_W:0] rem;
  logic [IDX_W-1:0] div;
  logic [4:0] count;
  logic down;
  logic [VAL_W-1:0] base;

  wire down_now = end_value < start_value;
  wire [VAL_W-1:0] span = down_now ? start_value - end_value : end_value - start_value;
  wire [IDX_W-1:0] width = last_idx - first_idx;
  wire [NUM_W-1:0] numer = NUM_W'(span) * NUM_W'(idx - first_idx);
  wire [IDX_W:0] rem_shift = {rem[IDX_W-1:0], quo[NUM_W-1]};
  wire fits = rem_shift >= {1'b0, div};

  // Evenly spaced values: start +/- span * offset / width
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      quo <= '0;
      rem <= '0;
      div <= '0;
      count <= 5'h00;
      down <= 1'b0;
      base <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      result <= '0;
    end else begin
      done <= 1'b0;
      if (go && !busy) begin
        busy <= 1'b1;
        quo <= (width == '0) ? '0 : numer;
        rem <= '0;
        div <= width;
        count <= (width == '0) ? 5'h00 : 5'(NUM_W);
        down <= down_now;
        base <= start_value;
      end else if (busy) begin
        if (count == 5'h00) begin
          busy <= 1'b0;
          done <= 1'b1;
          result <= down ? base - quo[VAL_W-1:0] : base + quo[VAL_W-1:0];
        end else begin
          rem <= fits ? rem_shift - {1'b0, div} : rem_shift;
          quo <= {quo[NUM_W-2:0], fits};
          count <= count - 5'h01;
        end
      end
    end
  end

  a_div_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    (go && !busy && width != '0) |=> ##27 done)
    else $error("interpolation result late or early");
  a_result_between: assert property (@(posedge hclk) disable iff (!hresetn)
    done |-> (down ? (result <= base && result >= end_value) :
                     (result >= base && result <= end_value)))
    else $error("interpolation result outside the fill span");
endmodule
`default_nettype wire

/* File: hw/fseq_pkg.sv */
/*
  Shared constants, register map and types of the fast step sequencer.
  Assumes a 10 MHz bus clock and a 32-bit AHB-Lite register bus.
*/
package fseq_pkg;
  localparam int IDX_W = 10;
  localparam int VAL_W = 16;
  localparam int LOOP_W = 14;
  localparam int TB_W = 15;
  localparam int STEPS_MAX = 1000;
  localparam logic [IDX_W-1:0] STEPS_MIN = 10'h003;
  localparam logic [LOOP_W-1:0] LOOP_MAX = 14'h270F;
  localparam int CLK_PERIOD_NS = 100;
  // Time base unit is 0.025 ms
  localparam int TICK_NS = 25000;
  localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
  localparam int TIME_BASE_MAX_NS = 600000000;
  localparam int TIME_BASE_MAX = TIME_BASE_MAX_NS / TICK_NS;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYCLES = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_LOOPS = 8'h08;
  localparam logic [7:0] OFS_FINAL = 8'h0C;
  localparam logic [7:0] OFS_TIME_BASE = 8'h10;
  localparam logic [7:0] OFS_HOLD_VALUE = 8'h14;
  localparam logic [7:0] OFS_STEP_SEL = 8'h18;
  localparam logic [7:0] OFS_STEP_DATA = 8'h1C;
  localparam logic [7:0] OFS_FILL_START = 8'h20;
  localparam logic [7:0] OFS_FILL_END = 8'h24;
  localparam logic [7:0] OFS_FILL_RANGE = 8'h28;
  localparam logic [7:0] OFS_STATUS = 8'h2C;
  localparam logic [7:0] OFS_POSITION = 8'h30;
  // Field positions
  localparam int CTRL_MODE_CR = 0;
  localparam int CTRL_HOLD = 1;
  localparam int CTRL_INFINITE = 2;
  localparam int CTRL_PREFILL = 3;
  localparam int CMD_START = 0;
  localparam int CMD_STOP = 1;
  localparam int CMD_INSERT = 2;
  localparam int CMD_DELETE = 3;
  localparam int CMD_FILL = 4;
  localparam int TRIG_BIT = 16;
  localparam int HI_FIELD = 16;
  // Values after reset
  localparam logic [LOOP_W-1:0] RST_LOOPS = 14'h0001;
  localparam logic [IDX_W-1:0] RST_FINAL = 10'h3E8;
  localparam logic [TB_W-1:0] RST_TIME_BASE = 15'h0001;

  typedef struct packed {
    logic trig;
    logic [VAL_W-1:0] value;
  } step_entry_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } bus_req_t;

  typedef struct packed {
    logic [VAL_W-1:0] setpoint;
    logic load_on;
    logic mode_cr;
  } load_drive_t;

  typedef enum {st_idle, st_run, st_done} seq_state_t;
  typedef enum {fl_idle, fl_launch, fl_wait} fill_state_t;
endpackage

/* File: hw/step_timer.sv */
/*
  Step period timer: a fixed 0.025 ms tick and a tick counter per step.
  Assumes reload is pulsed when a sequence starts.
*/
`timescale 1ns/1ps
`default_nettype none
module step_timer (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic reload,
  input wire logic [fseq_pkg::TB_W-1:0] period_ticks,
  output logic step_end
);
  import fseq_pkg::*;

  logic [7:0] pre;
  logic [TB_W-1:0] ticks;
  wire tick = (pre == 8'(TICK_CYCLES - 1));
  wire last_tick = tick && (ticks == period_ticks - 15'h0001);

  // Counter wraps at each boundary so every step lasts the same time
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre <= 8'h00;
      ticks <= 15'h0000;
    end else if (reload) begin
      pre <= 8'h00;
      ticks <= 15'h0000;
    end else begin
      pre <= tick ? 8'h00 : pre + 8'h01;
      if (tick) begin
        ticks <= last_tick ? 15'h0000 : ticks + 15'h0001;
      end
    end
  end

  assign step_end = last_tick && !reload;

  a_timer_spacing: assert property (@(posedge hclk) disable iff (!hresetn)
    step_end |=> (!step_end) [*8])
    else $error("step boundaries closer than one tick");
endmodule
`default_nettype wire

/* File: tb/load_stage_model.sv */
/*
  Load stage model: accepts the drive word every cycle and times trigger pulses.
  Assumes it shares the sequencer's clock and reset.
*/
`timescale 1ns/1ps
`default_nettype none
module load_stage_model (
  input wire logic hclk,
  input wire logic hresetn,
  input wire fseq_pkg::load_drive_t load_in,
  input wire logic pulse_in,
  output var int pulse_count,
  output var int pulse_width
);
  import fseq_pkg::*;
  int run;
  // Counts pulses and measures the length of the last one
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run <= 0;
      pulse_count <= 0;
      pulse_width <= 0;
    end else if (pulse_in === 1'b1) begin
      run <= run + 1;
      if (run == 0) begin
        pulse_count <= pulse_count + 1;
      end
    end else if (run != 0) begin
      pulse_width <= run;
      run <= 0;
    end
  end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
/*
  Random and corner-case bench of the fast step sequencer.
  Assumes a zero wait-state AHB-Lite slave and the load stage model.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import fseq_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic step_pulse_output;
  load_drive_t load_out;
  int err_total = 0;
  int total_checks = 0;
  int seed = 11318;
  int pc;
  int pw;
  logic [31:0] rd;
  logic [15:0] v [1:4];
  logic [15:0] hold;
  always #50 hclk = ~hclk;
  fast_step_sequencer i_fast_step_sequencer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .load_out(load_out), .step_pulse_output(step_pulse_output));
  load_stage_model i_load_stage_model (.hclk(hclk), .hresetn(hresetn), .load_in(load_out),
    .pulse_in(step_pulse_output), .pulse_count(pc), .pulse_width(pw));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        results;
      end
      @(posedge hclk);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    rdy;
    htrans <= 2'h0;
    hwdata <= d;
    rdy;
    rd = hrdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask
  task automatic wfill;
    int n;
    n = 0;
    bus(1'b0, OFS_STATUS, 32'h0);
    while (rd[2] !== 1'b0) begin
      n++;
      if (n > 200) begin
        err_total++;
        results;
      end
      bus(1'b0, OFS_STATUS, 32'h0);
    end
  endtask
  function automatic logic [31:0] fexp(input int i);
    return 32'h100 + 32'hC00 * (i - 1) / 3;
  endfunction
  initial begin
    repeat (100000) @(posedge hclk);
    err_total++;
    results;
  end
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rchk(OFS_LOOPS, 32'hFFFFFFFF, 32'h1);
    rchk(OFS_FINAL, 32'hFFFFFFFF, 32'h3E8);
    rchk(OFS_TIME_BASE, 32'hFFFFFFFF, 32'h1);
    rchk(8'h3C, 32'hFFFFFFFF, 32'h0);
    bus(1'b1, OFS_CMD, 32'h1);
    rchk(OFS_STATUS, 32'hFFFFFFFF, 32'h8);
    bus(1'b1, OFS_LOOPS, 32'h3FFF);
    rchk(OFS_LOOPS, 32'hFFFFFFFF, LOOP_MAX);
    bus(1'b1, OFS_TIME_BASE, 32'h0);
    rchk(OFS_TIME_BASE, 32'hFFFFFFFF, 32'h1);
    for (int i = 1; i <= 4; i++) begin
      v[i] = $random(seed);
      bus(1'b1, OFS_CMD, 32'h4);
      bus(1'b1, OFS_STEP_SEL, i);
      bus(1'b1, OFS_STEP_DATA, {15'h0, i[0], v[i]});
    end
    bus(1'b1, OFS_STEP_SEL, 32'h3FF);
    rchk(OFS_STEP_SEL, 32'hFFFFFFFF, 32'h4);
    hold = $random(seed);
    bus(1'b1, OFS_HOLD_VALUE, hold);
    bus(1'b1, OFS_LOOPS, 32'h2);
    bus(1'b1, OFS_FINAL, 32'h3);
    bus(1'b1, OFS_TIME_BASE, 32'h2);
    bus(1'b1, OFS_CTRL, 32'h3);
    bus(1'b1, OFS_CMD, 32'h1);
    for (int l = 0; l < 6; l++) begin
      @(negedge hclk);
      check(load_out, {v[l % 3 + 1], 2'h3});
      check(step_pulse_output, l % 3 != 1);
      repeat (2 * TICK_CYCLES) @(posedge hclk);
    end
    @(negedge hclk);
    check(load_out, {hold, 2'h3});
    check(pc, 4);
    check(pw, PULSE_CYCLES);
    @(posedge hclk);
    rchk(OFS_STATUS, 32'h03FF0003, 32'h00040002);
    bus(1'b1, OFS_CTRL, 32'h0);
    bus(1'b1, OFS_LOOPS, 32'h1);
    bus(1'b1, OFS_CMD, 32'h1);
    repeat (6 * TICK_CYCLES) @(posedge hclk);
    @(negedge hclk);
    check(load_out, 32'h0);
    @(posedge hclk);
    bus(1'b1, OFS_CMD, 32'h8);
    bus(1'b1, OFS_CMD, 32'h8);
    rchk(OFS_STATUS, 32'h03FF0000, 32'h00030000);
    bus(1'b1, OFS_FILL_START, 32'h100);
    bus(1'b1, OFS_FILL_END, 32'hD00);
    bus(1'b1, OFS_FILL_RANGE, 32'h00040001);
    bus(1'b1, OFS_CMD, 32'h10);
    wfill;
    bus(1'b1, OFS_CTRL, 32'h8);
    bus(1'b1, OFS_CMD, 32'h4);
    wfill;
    for (int i = 1; i <= 4; i++) begin
      bus(1'b1, OFS_STEP_SEL, i);
      rchk(OFS_STEP_DATA, 32'hFFFF, fexp(i));
    end
    bus(1'b1, OFS_CTRL, 32'h4);
    bus(1'b1, OFS_CMD, 32'h1);
    repeat (6 * TICK_CYCLES + 100) @(posedge hclk);
    rchk(OFS_POSITION, 32'hFFFFFFFF, 32'h00020001);
    rchk(OFS_STATUS, 32'h3, 32'h1);
    bus(1'b1, OFS_CMD, 32'h2);
    @(negedge hclk);
    check(load_out, 32'h0);
    @(posedge hclk);
    rchk(OFS_STATUS, 32'h3, 32'h0);
    results;
  end
endmodule
`default_nettype wire
